//--- design/fdcr_regs.sv
// Rate/precompensation, data port with execution FIFO, drive input register
////////////////////////////////////////////////////////////////////////////////
module fdcr_regs import fdcr_pkg::*; #(
    parameter int DEPTH = 16,
    parameter int DRP_1M_NS = 1000,
    parameter int DRP_500K_NS = 2000,
    parameter int DRP_300K_NS = 3333,
    parameter int DRP_250K_NS = 4000,
    parameter int ICP_NS = 42
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic disk_changed_input,
    input wire logic [7:0] current_track,
    output logic [2:0] write_shift_steps,
    output logic [1:0] rate_select,
    input wire logic [7:0] disk_in_data,
    input wire logic disk_in_valid,
    output logic disk_in_ready,
    output logic [7:0] disk_out_data,
    output logic disk_out_valid,
    input wire logic disk_out_ready,
    output logic dma_request,
    input wire logic dma_ack,
    input wire logic [7:0] dma_wr_data,
    output logic [7:0] dma_rd_data,
    output logic [7:0] cmd_byte,
    output logic cmd_byte_valid,
    input wire logic [7:0] result_byte,
    input wire logic result_valid,
    output logic result_take
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_W = (AW + 1)'(DEPTH);
    localparam logic [AW:0] ONE_W = (AW + 1)'(1);
    localparam logic [3:0] GAP_W = 4'(GAP_CYC);

    logic [1:0] rate_reg;
    logic [2:0] shift_reg;
    fdcr_cfg_t cfg_reg;
    fdcr_phase_t phase_reg;
    logic diag_reg, dir_read_reg, dma_mode_reg;
    logic [7:0] mem [DEPTH];
    logic [AW-1:0] wp_reg, rp_reg;
    logic [AW:0] count_reg, count_next, lim, level_next;
    logic aw_hold_reg, w_hold_reg, aw_hold_next, w_hold_next, wr_fire, rd_fire;
    logic [7:0] awaddr_reg, waddr;
    logic [31:0] wdata_reg, wdata;
    logic [3:0] wstrb_reg, wstrb;
    logic sw_rst, ctrl_wr, data_wr, data_rd, exec, fifo_on, host_xfer, push, pop;
    logic [3:0] thr_eff, gap_reg, gap_next;
    logic serve_reg, serve_next;
    logic [31:0] rdata_c;
    logic [1:0] rresp_c;
    logic [7:0] dir_val, msr_val;
    logic [2:0] steps_c;
    logic [23:0] budget_reg;
    int drp_ns;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: address and data taken in either order, answer a cycle later
    always_comb begin
        aw_hold_next = aw_hold_reg | (s_axi_awvalid & s_axi_awready);
        w_hold_next = w_hold_reg | (s_axi_wvalid & s_axi_wready);
        wr_fire = aw_hold_next & w_hold_next & !s_axi_bvalid;
        waddr = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
        wdata = w_hold_reg ? wdata_reg : s_axi_wdata;
        wstrb = w_hold_reg ? wstrb_reg : s_axi_wstrb;
        rd_fire = s_axi_arvalid & s_axi_arready;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else begin
            aw_hold_reg <= aw_hold_next & !wr_fire;
            w_hold_reg <= w_hold_next & !wr_fire;
            s_axi_awready <= !(aw_hold_next & !wr_fire);
            s_axi_wready <= !(w_hold_next & !wr_fire);
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                case (waddr)
                    OFF_RATE, OFF_DATA, OFF_CCR, OFF_CFG, OFF_CTRL: s_axi_bresp <= RESP_OKAY;
                    OFF_DIR, OFF_STAT, OFF_BUDGET: s_axi_bresp <= RESP_SLVERR;
                    default: s_axi_bresp <= RESP_DECERR;
                endcase
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !(rd_fire | (s_axi_rvalid & !s_axi_rready));
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdata_c;
                s_axi_rresp <= rresp_c;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access decode
    assign sw_rst = wr_fire & wstrb[0] & wdata[SWRST_BIT]
                    & (waddr == OFF_RATE || waddr == OFF_CTRL);
    assign ctrl_wr = wr_fire & wstrb[0] & (waddr == OFF_CTRL);
    assign data_wr = wr_fire & wstrb[0] & (waddr == OFF_DATA);
    assign data_rd = rd_fire & (s_axi_araddr == OFF_DATA);
    assign exec = (phase_reg == FDCR_PH_EXEC);
    assign fifo_on = cfg_reg.fifo_en & !(dir_read_reg ? cfg_reg.rd_off : cfg_reg.wr_off);
    assign lim = fifo_on ? DEPTH_W : ONE_W;
    assign thr_eff = fifo_on ? cfg_reg.thr : 4'h0;
    // DMA, interrupt and polled service all count as one host transfer
    assign host_xfer = exec & ((dma_mode_reg & dma_ack)
                       | (dir_read_reg ? data_rd : data_wr));

    always_comb begin
        dir_val = diag_reg ? {disk_changed_input, 4'hf, rate_reg, rate_reg == RATE_300K
                  || rate_reg == RATE_RST}
                  : {disk_changed_input, 7'h00};
        case (phase_reg)
            FDCR_PH_CMD: msr_val = {1'b1, 1'b0, 6'h00};
            FDCR_PH_EXEC: msr_val = {dma_request, dir_read_reg, !dma_mode_reg, 1'b1, 4'h0};
            FDCR_PH_RES: msr_val = {result_valid, 1'b1, 1'b0, 1'b1, 4'h0};
            default: msr_val = 8'h00;
        endcase
        rresp_c = RESP_OKAY;
        rdata_c = 32'h0;
        case (s_axi_araddr)
            OFF_DATA: rdata_c = {24'h0, exec ? mem[rp_reg] : result_byte};
            OFF_DIR: rdata_c = {24'h0, dir_val};
            OFF_CFG: rdata_c = {8'h00, cfg_reg.start_track, 4'h0, cfg_reg.thr, 3'h0, cfg_reg.lock,
                     cfg_reg.burst, cfg_reg.wr_off, cfg_reg.rd_off, cfg_reg.fifo_en};
            OFF_CTRL: rdata_c = {27'h0, dma_mode_reg, dir_read_reg, phase_reg, diag_reg};
            OFF_STAT: rdata_c = {15'h0, dma_request, 3'h0, 5'(count_reg), msr_val};
            OFF_BUDGET: rdata_c = {8'h00, budget_reg};
            OFF_RATE, OFF_CCR: rresp_c = RESP_SLVERR;
            default: rresp_c = RESP_DECERR;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Rate and shift settings; bits 5 and 6 of the rate write are ignored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rate_reg <= RATE_RST;
            shift_reg <= SHIFT_RST;
        end else if (wr_fire && wstrb[0]) begin
            if (waddr == OFF_RATE) begin
                rate_reg <= wdata[RATE_LSB +: 2];
                shift_reg <= wdata[SHIFT_LSB +: 3];
            end else if (waddr == OFF_CCR) begin
                rate_reg <= wdata[RATE_LSB +: 2];
            end
        end
    end

    always_comb begin
        case (shift_reg)
            SHIFT_NONE: steps_c = 3'h0;
            SHIFT_DEFAULT: steps_c = (rate_reg == RATE_1M) ? STEPS_1M_DEF : STEPS_LOW_DEF;
            default: steps_c = shift_reg;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            write_shift_steps <= 3'h0;
            rate_select <= RATE_RST;
        end else begin
            write_shift_steps <= (current_track >= cfg_reg.start_track) ? steps_c : 3'h0;
            rate_select <= rate_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and control; soft reset keeps a locked FIFO enabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_reg <= CFG_RST;
        end else begin
            if (wr_fire && waddr == OFF_CFG) begin
                if (wstrb[0]) begin
                    cfg_reg.fifo_en <= wdata[CFG_EN_BIT];
                    cfg_reg.rd_off <= wdata[CFG_RDOFF_BIT];
                    cfg_reg.wr_off <= wdata[CFG_WROFF_BIT];
                    cfg_reg.burst <= wdata[CFG_BURST_BIT];
                    cfg_reg.lock <= wdata[CFG_LOCK_BIT];
                end
                if (wstrb[1]) begin
                    cfg_reg.thr <= wdata[CFG_THR_LSB +: 4];
                end
                if (wstrb[2]) begin
                    cfg_reg.start_track <= wdata[CFG_TRK_LSB +: 8];
                end
            end
            if (sw_rst && !cfg_reg.lock) begin
                cfg_reg.fifo_en <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_reg <= FDCR_PH_CMD;
            diag_reg <= 1'b0;
            dir_read_reg <= 1'b0;
            dma_mode_reg <= 1'b0;
        end else if (sw_rst) begin
            phase_reg <= FDCR_PH_CMD;
        end else if (ctrl_wr) begin
            diag_reg <= wdata[CTRL_DIAG_BIT];
            dir_read_reg <= wdata[CTRL_DIR_BIT];
            dma_mode_reg <= wdata[CTRL_DMA_BIT];
            case (wdata[CTRL_PH_LSB +: 2])
                2'h1: phase_reg <= FDCR_PH_EXEC;
                2'h2: phase_reg <= FDCR_PH_RES;
                default: phase_reg <= FDCR_PH_CMD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command and result bytes skip the FIFO entirely
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_byte <= 8'h00;
            cmd_byte_valid <= 1'b0;
            result_take <= 1'b0;
        end else begin
            cmd_byte_valid <= data_wr & (phase_reg == FDCR_PH_CMD);
            result_take <= data_rd & (phase_reg == FDCR_PH_RES) & result_valid;
            if (data_wr && phase_reg == FDCR_PH_CMD) begin
                cmd_byte <= wdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Execution FIFO; disabled means one byte deep
    always_comb begin
        push = dir_read_reg ? (disk_in_valid & disk_in_ready) : (host_xfer & (count_reg < lim));
        pop = dir_read_reg ? (host_xfer & (count_reg != '0))
                           : ((count_reg != '0) & (!disk_out_valid | disk_out_ready));
        if (sw_rst || ctrl_wr) begin
            count_next = '0;
        end else begin
            count_next = count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
        end
        level_next = dir_read_reg ? count_next : lim - count_next;
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_reg] <= (dir_read_reg ? disk_in_data : (dma_mode_reg && dma_ack ? dma_wr_data
                            : wdata[7:0]));
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
            count_reg <= '0;
            disk_in_ready <= 1'b0;
            disk_out_valid <= 1'b0;
            disk_out_data <= 8'h00;
            dma_rd_data <= 8'h00;
        end else begin
            count_reg <= count_next;
            wp_reg <= (sw_rst || ctrl_wr) ? '0 : wp_reg + AW'(push);
            rp_reg <= (sw_rst || ctrl_wr) ? '0 : rp_reg + AW'(pop);
            // Ready follows next count so a full FIFO never takes one more
            disk_in_ready <= exec & dir_read_reg & !ctrl_wr & !sw_rst & (count_next < lim);
            if (host_xfer && dir_read_reg) begin
                dma_rd_data <= mem[rp_reg];
            end
            if (sw_rst || ctrl_wr) begin
                disk_out_valid <= 1'b0;
            end else if (!dir_read_reg && pop) begin
                disk_out_valid <= 1'b1;
                disk_out_data <= mem[rp_reg];
            end else if (disk_out_ready) begin
                disk_out_valid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Service request: burst holds until drained (read) or filled (write), non-burst gaps each byte
    always_comb begin
        if (serve_reg) begin
            serve_next = (level_next != '0);
        end else begin
            serve_next = (level_next >= (AW + 1)'(thr_eff) + ONE_W);
        end
        if (host_xfer && !cfg_reg.burst) begin
            gap_next = GAP_W;
        end else begin
            gap_next = (gap_reg != 4'h0) ? gap_reg - 4'h1 : 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !exec || sw_rst || ctrl_wr) begin
            serve_reg <= 1'b0;
            gap_reg <= 4'h0;
            dma_request <= 1'b0;
        end else begin
            serve_reg <= serve_next;
            gap_reg <= gap_next;
            dma_request <= serve_next & (gap_next == 4'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host service budget in ns; periods are parameters, not measured
    always_comb begin
        case (rate_reg)
            RATE_1M: drp_ns = DRP_1M_NS;
            RATE_500K: drp_ns = DRP_500K_NS;
            RATE_300K: drp_ns = DRP_300K_NS;
            default: drp_ns = DRP_250K_NS;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            budget_reg <= 24'h0;
        end else begin
            budget_reg <= 24'((int'(thr_eff) + 1) * 8 * drp_ns - 16 * ICP_NS);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    no_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
        (shift_reg == SHIFT_NONE) |=> (write_shift_steps == 3'h0))
        else $error("shift 111 did not give zero steps");
    default_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
        (shift_reg == SHIFT_DEFAULT && current_track >= cfg_reg.start_track)
        |=> (write_shift_steps == ($past(rate_reg) == RATE_1M ? 3'h1 : 3'h3)))
        else $error("default shift wrong for rate");
    track_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (current_track < cfg_reg.start_track) |=> (write_shift_steps == 3'h0))
        else $error("shift applied below start track");
    hw_rate_a: assert property (@(posedge clk) !rst_n |=> (rate_reg == 2'h2 && !cfg_reg.fifo_en
        && cfg_reg.thr == 4'h0))
        else $error("hard reset state wrong");
    swrst_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sw_rst && cfg_reg.lock && cfg_reg.fifo_en && !(waddr == OFF_CFG && wr_fire))
        |=> (cfg_reg.fifo_en && rate_reg == ($past(waddr) == OFF_RATE
        ? $past(wdata[RATE_LSB +: 2]) : $past(rate_reg))))
        else $error("locked FIFO or rate lost on soft reset");
    gap_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        (dma_request && host_xfer && !cfg_reg.burst) |=> !dma_request [*7])
        else $error("non-burst gap shorter than seven cycles");
    burst_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (dma_request && cfg_reg.burst && level_next != '0 && !ctrl_wr && !sw_rst)
        |=> dma_request)
        else $error("burst request dropped early");
    cmd_bypass_a: assert property (@(posedge clk) disable iff (!rst_n)
        (data_wr && phase_reg == FDCR_PH_CMD) |=> (cmd_byte_valid && $stable(count_reg)))
        else $error("command byte touched the FIFO");
    diag_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_fire && s_axi_araddr == OFF_DIR && diag_reg)
        |=> (s_axi_rdata[6:1] == {4'hf, $past(rate_reg)}))
        else $error("diagnostic input register bits wrong");
    density_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_fire && s_axi_araddr == OFF_DIR && diag_reg && rate_reg == RATE_500K)
        |=> !s_axi_rdata[0])
        else $error("density bit high at 500k");
endmodule : fdcr_regs

//--- design/fdcr_pkg.sv
// Shared constants and types for the rate, FIFO and drive-input register bank
package fdcr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_RATE = 8'h00;
    localparam logic [7:0] OFF_DATA = 8'h04;
    localparam logic [7:0] OFF_DIR = 8'h08;
    localparam logic [7:0] OFF_CCR = 8'h0c;
    localparam logic [7:0] OFF_CFG = 8'h10;
    localparam logic [7:0] OFF_CTRL = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    localparam logic [7:0] OFF_BUDGET = 8'h1c;
    // Rate / shift register fields
    localparam int RATE_LSB = 0;
    localparam int SHIFT_LSB = 2;
    localparam int SWRST_BIT = 7;
    localparam logic [1:0] RATE_RST = 2'h2;
    localparam logic [1:0] RATE_1M = 2'h3;
    localparam logic [1:0] RATE_500K = 2'h0;
    localparam logic [1:0] RATE_300K = 2'h1;
    localparam logic [2:0] SHIFT_RST = 3'h0;
    localparam logic [2:0] SHIFT_NONE = 3'h7;
    localparam logic [2:0] SHIFT_DEFAULT = 3'h0;
    localparam logic [2:0] STEPS_1M_DEF = 3'h1;
    localparam logic [2:0] STEPS_LOW_DEF = 3'h3;
    // Configuration register fields
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_RDOFF_BIT = 1;
    localparam int CFG_WROFF_BIT = 2;
    localparam int CFG_BURST_BIT = 3;
    localparam int CFG_LOCK_BIT = 4;
    localparam int CFG_THR_LSB = 8;
    localparam int CFG_TRK_LSB = 16;
    // Control register fields
    localparam int CTRL_DIAG_BIT = 0;
    localparam int CTRL_PH_LSB = 1;
    localparam int CTRL_DIR_BIT = 3;
    localparam int CTRL_DMA_BIT = 4;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Timing
    localparam int CLK_NS = 50;
    localparam int GAP_NS = 350;
    localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {FDCR_PH_CMD, FDCR_PH_EXEC, FDCR_PH_RES} fdcr_phase_t;

    typedef struct packed {
        logic [7:0] start_track;
        logic [3:0] thr;
        logic lock;
        logic burst;
        logic wr_off;
        logic rd_off;
        logic fifo_en;
    } fdcr_cfg_t;

    localparam fdcr_cfg_t CFG_RST = '0;
endpackage : fdcr_pkg

//--- dv/fdcr_dma_model.sv
// Host DMA controller model that answers service requests after a wait
module fdcr_dma_model #(
    parameter int DLY = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic dma_request,
    input wire logic [7:0] dma_rd_data,
    output logic dma_ack,
    output logic [7:0] last_byte,
    output logic [7:0] n_bytes,
    output logic [7:0] min_gap
);
    timeunit 1ns;
    timeprecision 1ns;
    int wait_cnt;
    int low_cnt;
    logic took;
    always @(posedge clk) begin
        if (!rst_n) begin
            dma_ack <= 1'b0;
            took <= 1'b0;
            n_bytes <= 8'h00;
            min_gap <= 8'hff;
            wait_cnt <= 0;
            low_cnt <= 0;
        end else begin
            took <= dma_ack;
            if (took) begin
                last_byte <= dma_rd_data;
                n_bytes <= n_bytes + 8'h01;
            end
            // Answer well inside the service budget
            if (dma_ack) begin
                dma_ack <= 1'b0;
            end else if (dma_request === 1'b1 && wait_cnt >= DLY) begin
                dma_ack <= 1'b1;
                wait_cnt <= 0;
            end else if (dma_request === 1'b1) begin
                wait_cnt <= wait_cnt + 1;
            end
            // Low spans only count once traffic has started
            if (dma_request === 1'b0) begin
                low_cnt <= low_cnt + 1;
            end else begin
                if (low_cnt > 0 && n_bytes > 0 && low_cnt < min_gap) min_gap <= 8'(low_cnt);
                low_cnt <= 0;
            end
        end
    end
endmodule : fdcr_dma_model

//--- dv/fdcr_regs_tb_top.sv
// Bench for the rate, data port and drive input register bank
module fdcr_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import fdcr_pkg::*;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, dchg = 1, div = 0;
    logic [7:0] awa = 0, ara = 0, did = 0, trk = 0, lb, nb, mg, cb, dod;
    logic [3:0] ws = 4'hf;
    logic [31:0] wd = 0, rd;
    logic [1:0] bresp, rresp, rsel;
    logic [2:0] steps;
    logic awr, wr, bv, arr, rv, dir_rdy, req, ack;
    logic [7:0] rdd;
    int mismatches = 0, n_checks = 0;
    always #25 clk = ~clk;
    fdcr_regs uut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .disk_changed_input(dchg),
        .current_track(trk), .write_shift_steps(steps), .rate_select(rsel),
        .disk_in_data(did), .disk_in_valid(div), .disk_in_ready(dir_rdy), .disk_out_data(dod),
        .disk_out_valid(), .disk_out_ready(1'b1), .dma_request(req), .dma_ack(ack),
        .dma_wr_data(8'h00), .dma_rd_data(rdd), .cmd_byte(cb), .cmd_byte_valid(),
        .result_byte(8'h00), .result_valid(1'b0), .result_take());
    fdcr_dma_model #(.DLY(1)) dma (.clk(clk), .rst_n(rst_n), .dma_request(req),
        .dma_rd_data(rdd), .dma_ack(ack), .last_byte(lb), .n_bytes(nb), .min_gap(mg));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int t;
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        br <= 1;
        t = 0;
        do begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
            t++;
        end while (bv !== 1'b1 && t < 50);
        br <= 0;
        chk({31'h0, bv}, 32'h1);
        chk({30'h0, bresp}, {30'h0, er});
        // One idle edge so registered outputs settle and ready is not reassigned
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
        int t;
        ara <= a;
        arv <= 1;
        rr <= 1;
        t = 0;
        do begin
            @(posedge clk);
            if (arr) arv <= 0;
            t++;
        end while (rv !== 1'b1 && t < 50);
        rr <= 0;
        chk({31'h0, rv}, 32'h1);
        chk(rd, ex);
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge clk);
    endtask : rd_reg
    task automatic disk_push(input logic [7:0] base);
        for (int i = 0; i < 4; i++) begin
            did <= base + 8'(i);
            div <= 1;
            do @(posedge clk); while (dir_rdy !== 1'b1);
        end
        div <= 0;
        repeat (80) @(posedge clk);
    endtask : disk_push
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        chk({30'h0, rsel}, 32'h2);
        rd_reg(OFF_BUDGET, 32'd31328, RESP_OKAY);
        rd_reg(OFF_DIR, 32'h80, RESP_OKAY);
        wr_reg(OFF_DIR, 32'h0, RESP_SLVERR);
        rd_reg(8'h20, 32'h0, RESP_DECERR);
        wr_reg(OFF_CFG, 32'h500, RESP_OKAY);
        rd_reg(OFF_BUDGET, 32'd31328, RESP_OKAY);
        ws <= 4'h1;
        wr_reg(OFF_CFG, 32'h5, RESP_OKAY);
        rd_reg(OFF_BUDGET, 32'd31328, RESP_OKAY);
        wr_reg(OFF_CFG, 32'h1, RESP_OKAY);
        ws <= 4'hf;
        rd_reg(OFF_BUDGET, 32'd191328, RESP_OKAY);
        wr_reg(OFF_CTRL, 32'h01, RESP_OKAY);
        for (int r = 0; r < 4; r++) begin
            wr_reg(OFF_RATE, 32'(r), RESP_OKAY);
            chk({30'h0, rsel}, 32'(r));
            chk({29'h0, steps}, (r == 3) ? 32'h1 : 32'h3);
            rd_reg(OFF_DIR, {24'h0, 1'b1, 4'hf, 2'(r), 1'(r == 1 || r == 2)},
                RESP_OKAY);
        end
        for (int c = 0; c < 8; c++) begin
            wr_reg(OFF_RATE, 32'((c << 2) | 3), RESP_OKAY);
            chk({29'h0, steps}, (c == 7) ? 32'h0 : (c == 0) ? 32'h1 : 32'(c));
        end
        wr_reg(OFF_CCR, 32'h0, RESP_OKAY);
        chk({30'h0, rsel}, 32'h0);
        wr_reg(OFF_RATE, 32'h3, RESP_OKAY);
        chk({30'h0, rsel}, 32'h3);
        wr_reg(OFF_CFG, 32'h50501, RESP_OKAY);
        chk({29'h0, steps}, 32'h0);
        trk <= 8'h05;
        repeat (2) @(posedge clk);
        chk({29'h0, steps}, 32'h1);
        wr_reg(OFF_CTRL, 32'h80, RESP_OKAY);
        chk({30'h0, rsel}, 32'h3);
        rd_reg(OFF_BUDGET, 32'd7328, RESP_OKAY);
        wr_reg(OFF_CFG, 32'h511, RESP_OKAY);
        wr_reg(OFF_CTRL, 32'h80, RESP_OKAY);
        rd_reg(OFF_BUDGET, 32'd47328, RESP_OKAY);
        wr_reg(OFF_DATA, 32'h5a, RESP_OKAY);
        chk({24'h0, cb}, 32'h5a);
        // Non-burst read direction: four bytes from the disk side
        wr_reg(OFF_CFG, 32'h001, RESP_OKAY);
        wr_reg(OFF_CTRL, 32'h1a, RESP_OKAY);
        disk_push(8'h30);
        chk({24'h0, nb}, 32'h4);
        chk({24'h0, lb}, 32'h33);
        chk({24'h0, mg}, 32'(GAP_CYC));
        // Burst: request holds until the FIFO drains
        wr_reg(OFF_CFG, 32'h009, RESP_OKAY);
        wr_reg(OFF_CTRL, 32'h1a, RESP_OKAY);
        disk_push(8'h40);
        chk({24'h0, nb}, 32'h8);
        chk({24'h0, lb}, 32'h43);
        // Polled write direction: byte reaches the disk side
        wr_reg(OFF_CTRL, 32'h02, RESP_OKAY);
        wr_reg(OFF_DATA, 32'ha5, RESP_OKAY);
        chk({24'h0, dod}, 32'ha5);
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        chk({30'h0, rsel}, 32'h2);
        rd_reg(OFF_BUDGET, 32'd31328, RESP_OKAY);
        finish_test();
    end
endmodule : fdcr_regs_tb_top
